//--- common/srq_pkg.sv
// shared constants and carriers for the session request control block
package srq_pkg;

  // apb register map, byte addresses of aligned 32-bit words
  localparam logic [7:0] OFF_CTRL     = 8'h00; // session request control
  localparam logic [7:0] OFF_INT_STAT = 8'h04; // sticky event bits, w1c
  localparam logic [7:0] OFF_INT_MASK = 8'h08; // event enables
  localparam logic [7:0] OFF_STATUS   = 8'h0C; // live input view

  // control register field positions
  localparam int unsigned BIT_ENABLE = 0; // session_request_enable
  localparam int unsigned BIT_VPULSE = 1; // vbus_pulse
  localparam int unsigned BIT_DISCH  = 2; // vbus_discharge
  localparam int unsigned BIT_INITF  = 3; // initial_condition_fail, w1c
  localparam int unsigned BIT_BSESS  = 4; // b_session_ok, w1c
  localparam int unsigned BIT_LPULSE = 5; // line_pulse

  localparam int unsigned CTRL_W     = 8;
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  CTRL_RW    = 8'h27; // plain read/write bits
  localparam logic [7:0]  CTRL_W1C   = 8'h18; // write-one-to-clear bits

  // event bits of the status and mask registers
  localparam int unsigned EV_BSESS = 0; // b-session became valid
  localparam int unsigned EV_INITF = 1; // initial condition violated
  localparam int unsigned EV_VBUS  = 2; // vbus crossed sensing level
  localparam int unsigned EV_DISCH = 3; // discharge time elapsed
  localparam int unsigned EV_W     = 4;
  localparam logic [3:0]  EV_RESET = 4'h0;

  // discharge time, in its own unit and in pclk cycles
  localparam int unsigned DISCH_TIME_MS = 30;
  localparam int unsigned CLK_KHZ       = 200000; // pclk 200 MHz
  localparam int unsigned DISCH_CNT_W   = 23;
  localparam int unsigned DISCH_CYCLES  = DISCH_TIME_MS * CLK_KHZ;
  localparam logic [22:0] CNT_ZERO      = 23'h000000;
  localparam logic [22:0] CNT_ONE       = 23'h000001;

  localparam int unsigned SENSE_W = 4;

  // analog comparator levels from the vbus and line sensing
  typedef struct packed {
    logic session_valid; // vbus above b-session valid level
    logic sense_above;   // vbus above sensing level
    logic vbus_low;      // vbus below 0.8 v
    logic lines_se0;     // both data lines low
  } srq_sense_t;

  // two-stage synchroniser state
  typedef struct packed {
    logic [3:0] meta;   // first stage, read only by stable
    logic [3:0] stable; // second stage
  } srq_sync_t;

  // whole state of the control block, apart from the synchroniser flops in srq_sync
  typedef struct packed {
    logic [7:0]  ctrl;        // control register
    logic [3:0]  int_stat;    // sticky events
    logic [3:0]  int_mask;    // event enables
    logic [22:0] disch_cnt;   // cycles spent discharging
    logic        sense_prev;  // last sensing level, edge detect
    logic        pready;      // apb ready
    logic        pslverr;     // apb error
    logic [31:0] prdata;      // apb read data
    logic        irq;         // interrupt line
    logic        line_pullup; // data line pull-up drive
    logic        vbus_charge; // vbus charging source drive
    logic        vbus_dischg; // vbus discharge drive
    logic        sense_en;    // normal vbus sensing enable
  } srq_state_t;

endpackage

//--- src/srq_sync.sv
`timescale 1ns/100ps
// two flip-flop synchroniser for the comparator levels
module srq_sync (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  d,
  output logic [3:0]       q
);

  srq_pkg::srq_sync_t st;     // registered state
  srq_pkg::srq_sync_t nxt_st; // next state

  // first stage feeds only the second stage
  always_comb begin
    nxt_st        = st;
    nxt_st.meta   = d;
    nxt_st.stable = st.meta;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nxt_st;
    end
  end

  assign q = st.stable;

endmodule // srq_sync

//--- src/srq_ctrl.sv
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
// Behaviour
// - discharge bit drives vbus discharge until cleared, event and status after 30ms
// - enable on: request function on, sensing off
// - enable off: all request controls masked
// - vbus crossing during request raises event
// - initial fail bit w1c, re-set on bad lines while enabled and neither pulse is on
// - b-session bit latches high, w1c, re-sets
module srq_ctrl #(
  parameter logic [22:0] DISCH_CYCLES = 23'(srq_pkg::DISCH_CYCLES)
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic                     irq,
  input  wire srq_pkg::srq_sense_t sense_in,
  output logic                     line_pullup_on,
  output logic                     vbus_charge_on,
  output logic                     vbus_discharge_on,
  output logic                     vbus_sense_en
);

  srq_pkg::srq_state_t st;      // registered state
  srq_pkg::srq_state_t nxt_st;  // next state
  logic [3:0]          sense_q; // synchronised comparator levels
  srq_pkg::srq_sense_t sense;   // same, by field

  // comparators are asynchronous to pclk
  srq_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (sense_in),
    .q       (sense_q)
  );
  assign sense = sense_q;

  // decode a word address onto the map
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == srq_pkg::OFF_CTRL) || (a == srq_pkg::OFF_INT_STAT) ||
               (a == srq_pkg::OFF_INT_MASK) || (a == srq_pkg::OFF_STATUS);
  endfunction

  // read multiplexer, unused upper bits read zero
  function automatic logic [31:0] read_word(
    input logic [7:0]          a,
    input srq_pkg::srq_state_t s,
    input srq_pkg::srq_sense_t l
  );
    read_word = 32'h00000000;
    case (a)
      srq_pkg::OFF_CTRL:     read_word[7:0] = s.ctrl;
      srq_pkg::OFF_INT_STAT: read_word[3:0] = s.int_stat;
      srq_pkg::OFF_INT_MASK: read_word[3:0] = s.int_mask;
      srq_pkg::OFF_STATUS: begin
        read_word[3:0] = l;
        read_word[4]   = (s.disch_cnt == DISCH_CYCLES);
      end
      default:               read_word = 32'h00000000;
    endcase
  endfunction

  logic       enable;    // request function on
  logic       setup;     // apb setup cycle
  logic       wr_acc;    // apb write completes this edge
  logic       disching;  // discharge requested and allowed
  logic [3:0] ev;        // events raised this cycle
  logic       init_bad;  // initial condition violated now

  // next-state logic
  always_comb begin
    nxt_st   = st;
    enable   = st.ctrl[srq_pkg::BIT_ENABLE];
    setup    = psel && !penable;
    // zero wait states: ready rises in the first access cycle
    wr_acc   = psel && penable && st.pready && pwrite;
    ev       = srq_pkg::EV_RESET;
    // pulsing disturbs the lines on purpose, so the idle check
    // pauses while either pulse is on
    init_bad = enable && !st.ctrl[srq_pkg::BIT_LPULSE] &&
               !st.ctrl[srq_pkg::BIT_VPULSE] &&
               (!sense.vbus_low || !sense.lines_se0);
    disching = enable && st.ctrl[srq_pkg::BIT_DISCH];

    // apb answer, prepared in the setup cycle
    nxt_st.pready  = setup;
    nxt_st.pslverr = setup && !addr_hit(paddr);
    if (setup && !pwrite) begin
      nxt_st.prdata = read_word(paddr, st, sense);
    end else if (!psel) begin
      nxt_st.prdata = 32'h00000000;
    end

    // software writes: plain bits, then w1c bits
    if (wr_acc) begin
      case (paddr)
        srq_pkg::OFF_CTRL: begin
          nxt_st.ctrl = (pwdata[7:0] & srq_pkg::CTRL_RW) |
                        (st.ctrl & srq_pkg::CTRL_W1C & ~pwdata[7:0]);
        end
        srq_pkg::OFF_INT_STAT: begin
          nxt_st.int_stat = st.int_stat & ~pwdata[3:0];
        end
        srq_pkg::OFF_INT_MASK: begin
          nxt_st.int_mask = pwdata[3:0];
        end
        default: begin
          // status is read-only, others unmapped
        end
      endcase
    end

    // hardware sets win over a clear in the same cycle
    if (init_bad) begin
      nxt_st.ctrl[srq_pkg::BIT_INITF] = 1'b1;
      ev[srq_pkg::EV_INITF] = !st.ctrl[srq_pkg::BIT_INITF];
    end
    // latched even with enable off, firmware polls after disabling
    if (sense.session_valid) begin
      nxt_st.ctrl[srq_pkg::BIT_BSESS] = 1'b1;
      ev[srq_pkg::EV_BSESS] = !st.ctrl[srq_pkg::BIT_BSESS];
    end

    // vbus crossing the sensing level while a request runs
    nxt_st.sense_prev = sense.sense_above;
    ev[srq_pkg::EV_VBUS] = enable && sense.sense_above &&
                           !st.sense_prev;

    // discharge timer, saturates so the status bit can stay up
    if (!disching) begin
      nxt_st.disch_cnt = srq_pkg::CNT_ZERO;
    end else if (st.disch_cnt != DISCH_CYCLES) begin
      nxt_st.disch_cnt = st.disch_cnt + srq_pkg::CNT_ONE;
      ev[srq_pkg::EV_DISCH] =
        (st.disch_cnt == DISCH_CYCLES - srq_pkg::CNT_ONE);
    end

    // sticky event bits
    nxt_st.int_stat = nxt_st.int_stat | ev;
    nxt_st.irq      = |(nxt_st.int_stat & nxt_st.int_mask);

    // pin drives follow the new control value at the same edge;
    // with enable off every request control is masked
    nxt_st.line_pullup = nxt_st.ctrl[srq_pkg::BIT_ENABLE] &&
                         nxt_st.ctrl[srq_pkg::BIT_LPULSE];
    nxt_st.vbus_charge = nxt_st.ctrl[srq_pkg::BIT_ENABLE] &&
                         nxt_st.ctrl[srq_pkg::BIT_VPULSE];
    nxt_st.vbus_dischg = nxt_st.ctrl[srq_pkg::BIT_ENABLE] &&
                         nxt_st.ctrl[srq_pkg::BIT_DISCH];
    nxt_st.sense_en    = !nxt_st.ctrl[srq_pkg::BIT_ENABLE];
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.ctrl     <= srq_pkg::CTRL_RESET;
      st.int_stat <= srq_pkg::EV_RESET;
      st.int_mask <= srq_pkg::EV_RESET;
      st.sense_en <= 1'b1; // normal sensing out of reset
    end else begin
      st <= nxt_st;
    end
  end

  // outputs straight from flops
  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign irq               = st.irq;
  assign line_pullup_on    = st.line_pullup;
  assign vbus_charge_on    = st.vbus_charge;
  assign vbus_discharge_on = st.vbus_dischg;
  assign vbus_sense_en     = st.sense_en;

  // checks on the block's own outputs and registers
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // judged against the written word, not the register copy
  pullup_gate_a: assert property (
    (wr_acc && paddr == srq_pkg::OFF_CTRL) |=>
      line_pullup_on == ($past(pwdata[srq_pkg::BIT_ENABLE]) &&
                         $past(pwdata[srq_pkg::BIT_LPULSE])))
    else $error("line pull-up does not follow a control write");

  charge_mask_a: assert property (
    !st.ctrl[srq_pkg::BIT_ENABLE] |->
      !vbus_charge_on && !line_pullup_on && !vbus_discharge_on)
    else $error("request control active while disabled");

  sense_mode_a: assert property (
    $rose(st.ctrl[srq_pkg::BIT_ENABLE]) |-> !vbus_sense_en)
    else $error("vbus sensing left on while request enabled");

  disch_time_a: assert property (
    (vbus_discharge_on && st.disch_cnt == DISCH_CYCLES - srq_pkg::CNT_ONE)
      |=> st.int_stat[srq_pkg::EV_DISCH] &&
          st.disch_cnt == DISCH_CYCLES)
    else $error("discharge time not flagged");

  vbus_event_a: assert property (
    (st.ctrl[srq_pkg::BIT_ENABLE] && sense.sense_above && !st.sense_prev)
      |=> st.int_stat[srq_pkg::EV_VBUS])
    else $error("vbus crossing not flagged");

  bsess_latch_a: assert property (
    sense.session_valid |=> st.ctrl[srq_pkg::BIT_BSESS])
    else $error("b-session bit not latched");

  initf_set_a: assert property (
    init_bad |=> st.ctrl[srq_pkg::BIT_INITF] ##1
                 st.ctrl[srq_pkg::BIT_INITF] || !init_bad)
    else $error("initial condition failure not latched");

endmodule // srq_ctrl

//--- tb/srq_host_model.sv
`timescale 1ns/100ps
// far side: a-device host plus the vbus and line levels it sees
module srq_host_model (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          vbus_charge_on,
  input  wire logic          vbus_discharge_on,
  input  wire logic          line_pullup_on,
  input  wire logic          host_power,
  input  wire logic          bad_line,
  output srq_pkg::srq_sense_t sense_out
);
  logic [3:0] vbus_lvl_ff; // crude vbus level
  // charge source raises vbus, discharge lowers it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vbus_lvl_ff <= 4'h0;
    else if (vbus_charge_on && vbus_lvl_ff != 4'hF)
      vbus_lvl_ff <= vbus_lvl_ff + 4'h1;
    else if (vbus_discharge_on && vbus_lvl_ff != 4'h0)
      vbus_lvl_ff <= vbus_lvl_ff - 4'h1;
  end
  // host power wins over local level
  assign sense_out.session_valid = host_power;
  assign sense_out.sense_above = host_power | (vbus_lvl_ff >= 4'h4);
  assign sense_out.vbus_low = !host_power && vbus_lvl_ff == 4'h0;
  // pull-up or a faulty cable breaks single-ended zero
  assign sense_out.lines_se0 = !bad_line && !line_pullup_on;
endmodule // srq_host_model

//--- tb/session_request_control_bench.sv
`timescale 1ns/100ps
// top bench: apb master tasks and one task per scenario
module session_request_control_bench;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready, pslverr, irq;
  logic               pull_on, chg_on, dis_on, sense_en;
  logic               host_power = 1'b0; // a-device turns vbus on
  logic               bad_line = 1'b0;   // cable not at se0
  srq_pkg::srq_sense_t sense;
  int                 fails = 0;
  int                 num_checks = 0;
  logic [31:0]        r;
  logic               e;

  // small discharge count keeps the run short
  srq_ctrl #(.DISCH_CYCLES(23'h000014)) srq_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sense_in(sense),
    .line_pullup_on(pull_on), .vbus_charge_on(chg_on),
    .vbus_discharge_on(dis_on), .vbus_sense_en(sense_en));
  srq_host_model srq_host_model_inst (
    .pclk(pclk), .presetn(presetn), .vbus_charge_on(chg_on),
    .vbus_discharge_on(dis_on), .line_pullup_on(pull_on),
    .host_power(host_power), .bad_line(bad_line), .sense_out(sense));

  // 200 mhz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // mid-cycle, so pin checks see what the write launched
    @(negedge pclk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic results();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // reset values and normal sensing
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, r);
    chk("sense on", 32'h1, {31'h0, sense_en});
  endtask

  // enable, initial condition fail re-sets while lines are bad
  task automatic t_initial_condition_fail();
    bad_line <= 1'b1;
    apb(1'b1, 8'h00, 32'h01);
    chk("sense off", 32'h0, {31'h0, sense_en});
    idle(4);
    apb(1'b1, 8'h00, 32'h09);
    idle(4);
    apb(1'b0, 8'h00, 32'h0);
    chk("init fail", 32'h09, r);
    bad_line <= 1'b0;
    idle(4);
    apb(1'b1, 8'h00, 32'h09);
    apb(1'b0, 8'h00, 32'h0);
    chk("init clear", 32'h01, r);
  endtask

  // line pulse then vbus pulse drive pull-up and charge
  task automatic t_pulses();
    apb(1'b1, 8'h00, 32'h21);
    chk("pull-up", 32'h1, {31'h0, pull_on});
    apb(1'b1, 8'h00, 32'h01);
    chk("pull-up off", 32'h0, {31'h0, pull_on});
    apb(1'b1, 8'h00, 32'h03);
    chk("charge", 32'h1, {31'h0, chg_on});
    idle(10);
    apb(1'b1, 8'h00, 32'h01);
    chk("charge off", 32'h0, {31'h0, chg_on});
    apb(1'b0, 8'h04, 32'h0);
    chk("vbus event", 32'h4, r & 32'h4);
  endtask

  // disabled: pulse and discharge bits are masked at the pins
  task automatic t_masked();
    apb(1'b1, 8'h00, 32'h26);
    chk("masked", 32'h0, {29'h0, pull_on, chg_on, dis_on});
    chk("sense back", 32'h1, {31'h0, sense_en});
    apb(1'b1, 8'h00, 32'h00);
  endtask

  // discharge drives the pin and times out
  task automatic t_discharge();
    apb(1'b1, 8'h00, 32'h05);
    chk("discharge", 32'h1, {31'h0, dis_on});
    idle(30);
    apb(1'b0, 8'h0C, 32'h0);
    chk("disch done", 32'h10, r & 32'h10);
    apb(1'b0, 8'h04, 32'h0);
    chk("disch event", 32'h8, r & 32'h8);
    apb(1'b1, 8'h00, 32'h00);
  endtask

  // b-session latches, re-sets while valid, raises irq
  task automatic t_bsess();
    apb(1'b1, 8'h04, 32'hF);
    host_power <= 1'b1;
    idle(5);
    apb(1'b0, 8'h0C, 32'h0);
    chk("sense valid", 32'h8, r & 32'h8);
    apb(1'b0, 8'h00, 32'h0);
    chk("bsess set", 32'h10, r & 32'h10);
    apb(1'b1, 8'h08, 32'h1);
    idle(2);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h00, 32'h0);
    chk("bsess again", 32'h10, r & 32'h10);
    host_power <= 1'b0;
    idle(5);
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h00, 32'h0);
    chk("bsess clear", 32'h0, r & 32'h10);
    apb(1'b1, 8'h04, 32'hF);
    idle(2);
    chk("irq off", 32'h0, {31'h0, irq});
  endtask

  // unmapped address answers with an error
  task automatic t_unmapped();
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("err data", 32'h0, r);
  endtask

  initial begin
    idle(8);
    presetn <= 1'b1;
    t_reset();
    t_initial_condition_fail();
    t_pulses();
    t_masked();
    t_discharge();
    t_bsess();
    t_unmapped();
    results();
  end

  // hang guard
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // session_request_control_bench
